/* core/chan_ctrl.sv */
`timescale 1ns/1ps
`include "chan_ctrl_defines.svh"
module chan_ctrl
  import chan_ctrl_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            chan3_tick,
  output logic            chan4_tick,
  output logic      [1:0] chan2_swing_trim,
  output logic            chan2_termination_on,
  output logic            chan2_regulator_on,
  output logic            chan2_output_on,
  output logic      [1:0] chan3_swing_trim,
  output logic            chan3_termination_on,
  output logic            chan3_regulator_on,
  output logic            chan3_output_on,
  output logic            chan2_ratio_clear,
  output logic            chan3_ratio_clear,
  output logic            chan3_div_off,
  output logic            chan4_div_off
);
  typedef struct packed {
    drv_t       stg_drv2;
    byte_t      stg_ratio3;
    drv_t       stg_drv3;
    byte_t      stg_ratio4;
    drv_t       act_drv2;
    byte_t      act_ratio3;
    drv_t       act_drv3;
    byte_t      act_ratio4;
    logic       clr2;
    logic       clr3;
    logic       off3;
    logic       off4;
    byte_t      rdata;
  } state_t;

  localparam byte_t  DRV_INIT_BYTE = `DRV_RESET;
  localparam drv_t   DRV_INIT      = DRV_INIT_BYTE[`DRV_TRIM_HI:`DRV_OUT_BIT];
  // Reset image of every register, staging and active alike
  localparam state_t STATE_INIT    = '{
    stg_drv2:   DRV_INIT,
    stg_ratio3: `RATIO_RESET,
    stg_drv3:   DRV_INIT,
    stg_ratio4: `RATIO_RESET,
    act_drv2:   DRV_INIT,
    act_ratio3: `RATIO_RESET,
    act_drv3:   DRV_INIT,
    act_ratio4: `RATIO_RESET,
    clr2:       1'h0,
    clr3:       1'h0,
    off3:       1'h0,
    off4:       1'h0,
    rdata:      8'h00
  };

  state_t     s_r;
  state_t     s_nxt;
  logic [1:0] rst_pipe_r;
  logic       rst_sync_n;
  logic       tick3;
  logic       tick4;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'b00;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_r[1];

  // Reserved bits and the live clear bit are never stored
  function automatic drv_t drv_unpack(input byte_t v);
    drv_t d;
    d.trim = v[`DRV_TRIM_HI:`DRV_TRIM_LO];
    d.term = v[`DRV_TERM_BIT];
    d.regl = v[`DRV_REG_BIT];
    d.out  = v[`DRV_OUT_BIT];
    drv_unpack = d;
  endfunction

  // Reserved bits and the clear bit read back as zero
  function automatic byte_t drv_pack(input drv_t d);
    drv_pack = {2'h0, d.trim, d.term, d.regl, d.out, 1'h0};
  endfunction

  function automatic logic ratio_off(input byte_t r);
    ratio_off = (r == 8'h00);
  endfunction

  always_comb begin
    s_nxt      = s_r;
    s_nxt.clr2 = 1'h0;
    s_nxt.clr3 = 1'h0;
    // Decoded one cycle late so a tick already launched never overlaps off
    s_nxt.off3 = ratio_off(s_r.act_ratio3);
    s_nxt.off4 = ratio_off(s_r.act_ratio4);
    if (wr) begin
      unique case (addr)
        `ADDR_CHAN2_DRIVER_CTRL: begin
          s_nxt.stg_drv2 = drv_unpack(wdata);
          // Live bit: pulses at once, bypassing the staging copy
          s_nxt.clr2     = wdata[`DRV_CLEAR_BIT];
        end
        `ADDR_CHAN3_DIVIDE_RATIO: begin
          s_nxt.stg_ratio3 = wdata;
        end
        `ADDR_CHAN3_DRIVER_CTRL: begin
          s_nxt.stg_drv3 = drv_unpack(wdata);
          s_nxt.clr3     = wdata[`DRV_CLEAR_BIT];
        end
        `ADDR_CHAN4_DIVIDE_RATIO: begin
          s_nxt.stg_ratio4 = wdata;
        end
        `ADDR_UPDATE_CTRL: begin
          // All copies move together so the driver outputs never mix old and new settings
          if (wdata[0]) begin
            s_nxt.act_drv2   = s_r.stg_drv2;
            s_nxt.act_ratio3 = s_r.stg_ratio3;
            s_nxt.act_drv3   = s_r.stg_drv3;
            s_nxt.act_ratio4 = s_r.stg_ratio4;
          end
        end
        default: begin
        end
      endcase
    end
    s_nxt.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `ADDR_CHAN2_DRIVER_CTRL: begin
          s_nxt.rdata = drv_pack(s_r.stg_drv2);
        end
        `ADDR_CHAN3_DIVIDE_RATIO: begin
          s_nxt.rdata = s_r.stg_ratio3;
        end
        `ADDR_CHAN3_DRIVER_CTRL: begin
          s_nxt.rdata = drv_pack(s_r.stg_drv3);
        end
        `ADDR_CHAN4_DIVIDE_RATIO: begin
          s_nxt.rdata = s_r.stg_ratio4;
        end
        `ADDR_ACTIVE_BASE: begin
          s_nxt.rdata = drv_pack(s_r.act_drv2);
        end
        `ADDR_ACTIVE_BASE + 10'h001: begin
          s_nxt.rdata = s_r.act_ratio3;
        end
        `ADDR_ACTIVE_BASE + 10'h002: begin
          s_nxt.rdata = drv_pack(s_r.act_drv3);
        end
        `ADDR_ACTIVE_BASE + 10'h003: begin
          s_nxt.rdata = s_r.act_ratio4;
        end
        // Live divider status, as seen in the cycle the read is taken
        `ADDR_ACTIVE_BASE + 10'h004: begin
          s_nxt.rdata = {6'h00, tick4, tick3};
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r <= STATE_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Channel 3 restarts its count on the live clear pulse
  chan_divider u_div3 (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .ratio      (s_r.act_ratio3),
    .clear      (s_r.clr3),
    .tick       (tick3)
  );

  // Chan4 driver register lies outside; its clear never fires here
  chan_divider u_div4 (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .ratio      (s_r.act_ratio4),
    .clear      (1'h0),
    .tick       (tick4)
  );

  assign chan3_tick           = tick3;
  assign chan4_tick           = tick4;
  assign rdata                = s_r.rdata;
  assign chan2_swing_trim     = s_r.act_drv2.trim;
  assign chan2_termination_on = s_r.act_drv2.term;
  assign chan2_regulator_on   = s_r.act_drv2.regl;
  assign chan2_output_on      = s_r.act_drv2.out;
  assign chan3_swing_trim     = s_r.act_drv3.trim;
  assign chan3_termination_on = s_r.act_drv3.term;
  assign chan3_regulator_on   = s_r.act_drv3.regl;
  assign chan3_output_on      = s_r.act_drv3.out;
  assign chan2_ratio_clear    = s_r.clr2;
  assign chan3_ratio_clear    = s_r.clr3;
  assign chan3_div_off        = s_r.off3;
  assign chan4_div_off        = s_r.off4;
endmodule

/* core/chan_ctrl_defines.svh */
`ifndef CHAN_CTRL_DEFINES_SVH
`define CHAN_CTRL_DEFINES_SVH

`define ADDR_CHAN2_DRIVER_CTRL  10'h017
`define ADDR_CHAN3_DIVIDE_RATIO 10'h018
`define ADDR_CHAN3_DRIVER_CTRL  10'h019
`define ADDR_CHAN4_DIVIDE_RATIO 10'h01A
`define ADDR_UPDATE_CTRL        10'h01E
`define ADDR_ACTIVE_BASE        10'h020

`define DRV_RESET               8'h24
`define RATIO_RESET             8'h01
`define DRV_TRIM_HI             5
`define DRV_TRIM_LO             4
`define DRV_TERM_BIT            3
`define DRV_REG_BIT             2
`define DRV_OUT_BIT             1
`define DRV_CLEAR_BIT           0
`define DRV_RW_MASK             8'h3E

`endif

/* core/chan_ctrl_pkg.sv */
package chan_ctrl_pkg;
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic [1:0] trim;
    logic       term;
    logic       regl;
    logic       out;
  } drv_t;

  typedef struct packed {
    byte_t count;
    logic  tick;
  } div_t;
endpackage

/* core/chan_divider.sv */
`timescale 1ns/1ps
module chan_divider
  import chan_ctrl_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_sync_n,
  input  wire logic [7:0] ratio,
  input  wire logic       clear,
  output logic            tick
);
  div_t s_r;
  div_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (clear || ratio == 8'h00) begin
      s_nxt.count = 8'h00;
    end else if (s_r.count >= ratio - 8'h01) begin
      s_nxt.count = 8'h00;
      s_nxt.tick  = 1'b1;
    end else begin
      s_nxt.count = s_r.count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

/* testbench/chan_ctrl_sva.sv */
`timescale 1ns/1ps
module chan_ctrl_sva (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic [1:0] chan2_swing_trim,
  input wire logic       chan2_termination_on,
  input wire logic       chan2_regulator_on,
  input wire logic       chan2_ratio_clear,
  input wire logic       chan3_ratio_clear,
  input wire logic       chan3_tick,
  input wire logic       chan3_div_off,
  input wire logic       chan4_tick,
  input wire logic       chan4_div_off
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_clear_two_live: assert property (wr && addr == 10'h017 && wdata[0] |=> chan2_ratio_clear)
    else $error("chan2 clear pulse missing");
  a_clear_three_cause: assert property (chan3_ratio_clear |-> $past(wr && addr == 10'h019 && wdata[0]))
    else $error("chan3 clear without write");
  a_off_three_quiet: assert property (chan3_div_off |-> !chan3_tick)
    else $error("chan3 tick while off");
  a_off_four_quiet: assert property (chan4_div_off |-> !chan4_tick)
    else $error("chan4 tick while off");
  a_trim_reset_val: assert property ($rose(rst_n) |-> chan2_swing_trim == 2'h2)
    else $error("trim reset value wrong");
  a_term_reset_off: assert property ($rose(rst_n) |-> !chan2_termination_on)
    else $error("termination reset value wrong");
  a_reg_reset_on: assert property ($rose(rst_n) |-> chan2_regulator_on)
    else $error("regulator reset value wrong");
  a_trim_held: assert property (!(wr && addr == 10'h01E) |=> $stable(chan2_swing_trim))
    else $error("trim moved without update");
  a_clear_stops_tick: assert property (chan3_ratio_clear |=> !chan3_tick)
    else $error("chan3 tick right after clear");
endmodule
bind chan_ctrl chan_ctrl_sva u_sva (.*);

/* testbench/chan_ctrl_tb.sv */
`timescale 1ns/1ps
module chan_ctrl_tb;
  logic       sys_clk, rst_n, wr, rd, chan3_tick, chan4_tick, chan3_div_off, chan4_div_off;
  logic       chan2_termination_on, chan2_regulator_on, chan2_output_on, chan2_ratio_clear;
  logic       chan3_termination_on, chan3_regulator_on, chan3_output_on, chan3_ratio_clear;
  logic [1:0] chan2_swing_trim, chan3_swing_trim;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, drv2_seen, drv3_seen;
  int         num_errors, total_checks, cycles, ticks;
  chan_ctrl u_dut (.*);
  assign drv2_seen = {3'h0, chan2_swing_trim, chan2_termination_on, chan2_regulator_on, chan2_output_on};
  assign drv3_seen = {3'h0, chan3_swing_trim, chan3_termination_on, chan3_regulator_on, chan3_output_on};
  always #5 sys_clk = ~sys_clk;
  // Counted off the edge so the tick sample never races its update
  always @(negedge sys_clk) if (chan3_tick === 1'h1) ticks++;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'h1; addr <= a; wdata <= d;
    @(posedge sys_clk);
    wr <= 1'h0;
    #1;
  endtask
  task automatic get(input logic [9:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rd <= 1'h1; addr <= a;
    @(posedge sys_clk);
    rd <= 1'h0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic run_ticks(input logic [7:0] r);
    put(10'h018, r);
    put(10'h01E, 8'h01);
    repeat (4) @(posedge sys_clk);
    ticks = 0;
    repeat (30) @(posedge sys_clk);
  endtask
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0; rst_n = 1'h0; wr = 1'h0; rd = 1'h0; addr = 10'h000; wdata = 8'h00;
    num_errors = 0; total_checks = 0; cycles = 0; ticks = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    get(10'h017, 8'h24);
    get(10'h018, 8'h01);
    get(10'h019, 8'h24);
    get(10'h01A, 8'h01);
    put(10'h019, 8'h3F);
    chk("clear3", {7'h00, chan3_ratio_clear}, 8'h01);
    chk("out3", {7'h00, chan3_output_on}, 8'h00);
    get(10'h019, 8'h3E);
    put(10'h01E, 8'h01);
    chk("drv3", drv3_seen, 8'h1F);
    run_ticks(8'h03);
    chk("ticks3", 8'(ticks), 8'h0A);
    run_ticks(8'h00);
    chk("off3", {7'h00, chan3_div_off}, 8'h01);
    chk("ticks0", 8'(ticks), 8'h00);
    put(10'h017, 8'h0B);
    chk("clear2", {7'h00, chan2_ratio_clear}, 8'h01);
    chk("drv2_held", drv2_seen, 8'h12);
    put(10'h01A, 8'h00);
    put(10'h01E, 8'h01);
    chk("drv2", drv2_seen, 8'h05);
    get(10'h023, 8'h00);
    chk("off4", {7'h00, chan4_div_off}, 8'h01);
    get(10'h024, 8'h00);
    get(10'h3FF, 8'h00);
    summarize();
  end
endmodule
